// >>> verilog/status_word_flag_logic.sv
// Program status word flags: nesting level, bank enables, skip flags and carry.
`timescale 1ns/1ps
module status_word_flag_logic #(
    parameter int IRQ_N = status_word_pkg::IRQ_N
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_reset_load,
    input wire logic i_irq_entry,
    input wire logic i_irq_return,
    input wire logic [7:0] i_vector_byte,
    input wire logic [7:0] i_pop_word,
    input wire logic i_sw_write,
    input wire logic [11:0] i_sw_addr,
    input wire logic [3:0] i_sw_bit_en,
    input wire logic [3:0] i_sw_wdata,
    input wire logic i_skip_update,
    input wire logic [2:0] i_skip_value,
    input wire status_word_pkg::carry_op_type i_carry_op,
    input wire logic i_arith_carry,
    input wire logic i_mem_bit,
    input wire logic i_carry_test,
    input wire logic [IRQ_N-1:0] i_irq_pending,
    input wire logic [IRQ_N-1:0] i_irq_high,
    input wire logic [3:0] i_mem_bank_select,
    input wire logic [1:0] i_reg_bank_select,
    input wire logic [7:0] i_offset,
    output logic [7:0] o_status_word,
    output logic [7:0] o_push_word,
    output logic o_push_valid,
    output logic [1:0] o_nest_level,
    output logic o_carry,
    output logic o_skip_next,
    output logic [IRQ_N-1:0] o_irq_accept,
    output logic [11:0] o_phys_addr,
    output logic o_addr_ok,
    output logic [1:0] o_reg_bank
);
    typedef struct packed {
        logic [1:0] nest;
        logic mem_bank_enable;
        logic reg_bank_enable;
        logic carry;
        logic [2:0] skip;
        logic [7:0] push_word;
        logic push_valid;
        logic skip_next;
    } flag_state_type;

    flag_state_type st_r;
    flag_state_type st_nxt;
    logic [7:0] word_now;

    assign word_now = {st_r.nest, st_r.mem_bank_enable, st_r.reg_bank_enable, st_r.carry, st_r.skip};

    always_comb begin
        logic sw_hit;
        logic [3:0] nib;
        sw_hit = i_sw_write && (i_sw_addr == status_word_pkg::ADDR_FLAGS);
        nib = {st_r.nest, st_r.mem_bank_enable, st_r.reg_bank_enable};
        st_nxt = st_r;
        st_nxt.push_valid = 1'b0;
        st_nxt.skip_next = i_carry_test && st_r.carry;

        // Carry: only the listed operations and a return touch it.
        unique case (i_carry_op)
            status_word_pkg::cop_none: st_nxt.carry = st_r.carry;
            status_word_pkg::cop_arith: st_nxt.carry = i_arith_carry;
            status_word_pkg::cop_set: st_nxt.carry = 1'b1;
            status_word_pkg::cop_clear: st_nxt.carry = 1'b0;
            status_word_pkg::cop_invert: st_nxt.carry = !st_r.carry;
            status_word_pkg::cop_load_bit: st_nxt.carry = i_mem_bit;
            status_word_pkg::cop_and_bit: st_nxt.carry = st_r.carry & i_mem_bit;
            status_word_pkg::cop_or_bit: st_nxt.carry = st_r.carry | i_mem_bit;
            status_word_pkg::cop_xor_bit: st_nxt.carry = st_r.carry ^ i_mem_bit;
            default: st_nxt.carry = st_r.carry;
        endcase

        if (i_skip_update) begin
            st_nxt.skip = i_skip_value;
        end

        // Writes to the carry and skip nibble are dropped so only execution and return move them; internal reset also clears the skip flags.
        if (sw_hit) begin
            for (int b = 0; b < status_word_pkg::NIB_W; b++) begin
                if (i_sw_bit_en[b]) begin
                    nib[b] = i_sw_wdata[b];
                end
            end
            st_nxt.nest = nib[status_word_pkg::NB_NEST_HI:status_word_pkg::NB_NEST_LO];
            st_nxt.mem_bank_enable = nib[status_word_pkg::NB_EMB];
            st_nxt.reg_bank_enable = nib[status_word_pkg::NB_ERB];
        end

        if (i_irq_entry) begin
            st_nxt.push_word = word_now;
            st_nxt.push_valid = 1'b1;
            // The level saturates at two so a stray entry never lands on the undefined code.
            if (st_r.nest < status_word_pkg::NEST_BLOCK) begin
                st_nxt.nest = st_r.nest + 2'h1;
            end
            st_nxt.mem_bank_enable = i_vector_byte[status_word_pkg::VEC_EMB_BIT];
            st_nxt.reg_bank_enable = i_vector_byte[status_word_pkg::VEC_ERB_BIT];
        end

        if (i_irq_return) begin
            st_nxt.nest = i_pop_word[status_word_pkg::SW_NEST_HI:status_word_pkg::SW_NEST_LO];
            st_nxt.mem_bank_enable = i_pop_word[status_word_pkg::SW_EMB];
            st_nxt.reg_bank_enable = i_pop_word[status_word_pkg::SW_ERB];
            st_nxt.carry = i_pop_word[status_word_pkg::SW_CARRY];
            st_nxt.skip = i_pop_word[status_word_pkg::SW_SKIP_LSB +: status_word_pkg::SKIP_W];
        end

        // Internal reset keeps the carry, mirroring power-down retention.
        if (i_reset_load) begin
            st_nxt.nest = status_word_pkg::NEST_OPEN;
            st_nxt.skip = '0;
            st_nxt.mem_bank_enable = i_vector_byte[status_word_pkg::VEC_EMB_BIT];
            st_nxt.reg_bank_enable = i_vector_byte[status_word_pkg::VEC_ERB_BIT];
            st_nxt.push_valid = 1'b0;
            st_nxt.skip_next = 1'b0;
            st_nxt.carry = st_r.carry;
        end
    end

    // Power-on clears the carry too; software must not rely on that value.
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_status_word = word_now;
    assign o_push_word = st_r.push_word;
    assign o_push_valid = st_r.push_valid;
    assign o_nest_level = st_r.nest;
    assign o_carry = st_r.carry;
    assign o_skip_next = st_r.skip_next;

    irq_nest_gate #(
        .N(IRQ_N)
    ) u_gate (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_nest_level(st_r.nest),
        .i_pending(i_irq_pending),
        .i_high(i_irq_high),
        .o_accept(o_irq_accept)
    );

    bank_window u_window (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_emb(st_r.mem_bank_enable),
        .i_erb(st_r.reg_bank_enable),
        .i_mem_bank_select(i_mem_bank_select),
        .i_reg_bank_select(i_reg_bank_select),
        .i_offset(i_offset),
        .o_phys_addr(o_phys_addr),
        .o_addr_ok(o_addr_ok),
        .o_reg_bank(o_reg_bank)
    );

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    logic plain_entry;
    logic no_override;
    assign plain_entry = i_irq_entry && !i_irq_return && !i_reset_load;
    // Return and internal reset outrank every other status word update in the same cycle.
    assign no_override = !i_irq_return && !i_reset_load;

    a_entry_push: assert property (plain_entry |=> o_push_valid
        && o_push_word == $past(o_status_word))
        else $error("entry did not push the current status word");
    a_entry_level: assert property (
        plain_entry && o_nest_level == 2'h0 |=> o_nest_level == 2'h1)
        else $error("entry did not raise nesting level");
    a_entry_vector: assert property (plain_entry |=>
        o_status_word[5:4] == $past(i_vector_byte[7:6]))
        else $error("bank enables not loaded from vector byte");
    a_return_restore: assert property (
        i_irq_return && !i_reset_load |=> o_status_word == $past(i_pop_word))
        else $error("return did not restore the status word");
    a_reset_load: assert property (i_reset_load |=> o_nest_level == 2'h0
        && o_status_word[2:0] == 3'h0 && o_status_word[5:4] == $past(i_vector_byte[7:6])
        && o_carry == $past(o_carry))
        else $error("internal reset load wrong");
    a_skip_nowrite: assert property (
        !i_skip_update && !i_irq_return && !i_reset_load |=> $stable(o_status_word[2:0]))
        else $error("skip flags moved without execution");
    a_carry_hold: assert property (
        i_carry_op == status_word_pkg::cop_none && !i_irq_return |=> $stable(o_carry))
        else $error("carry changed without a carry operation");
    a_carry_set: assert property (
        i_carry_op == status_word_pkg::cop_set && !i_irq_return && !i_reset_load |=> o_carry)
        else $error("carry set did not set carry");
    a_carry_xor: assert property (
        i_carry_op == status_word_pkg::cop_xor_bit && !i_irq_return && !i_reset_load
        |=> o_carry == ($past(o_carry) ^ $past(i_mem_bit)))
        else $error("carry xor wrong");
    a_test_skip: assert property (
        i_carry_test && !i_reset_load |=> o_skip_next == $past(o_carry))
        else $error("carry test skip wrong");
    a_carry_clear: assert property (
        i_carry_op == status_word_pkg::cop_clear && no_override
        |=> !o_carry)
        else $error("carry clear did not clear carry");
    a_carry_invert: assert property (
        i_carry_op == status_word_pkg::cop_invert && no_override
        |=> o_carry == !$past(o_carry))
        else $error("carry invert wrong");
    a_carry_arith: assert property (
        i_carry_op == status_word_pkg::cop_arith && no_override
        |=> o_carry == $past(i_arith_carry))
        else $error("arithmetic carry not taken");
    a_carry_load: assert property (
        i_carry_op == status_word_pkg::cop_load_bit && no_override
        |=> o_carry == $past(i_mem_bit))
        else $error("bit load into carry wrong");
    a_carry_and: assert property (
        i_carry_op == status_word_pkg::cop_and_bit && no_override
        |=> o_carry == ($past(o_carry) & $past(i_mem_bit)))
        else $error("carry and wrong");
    a_carry_or: assert property (
        i_carry_op == status_word_pkg::cop_or_bit && no_override
        |=> o_carry == ($past(o_carry) | $past(i_mem_bit)))
        else $error("carry or wrong");
    a_skip_update: assert property (
        i_skip_update && no_override
        |=> o_status_word[2:0] == $past(i_skip_value))
        else $error("skip flags not taken from execution");
    a_flag_write: assert property (
        i_sw_write && i_sw_addr == status_word_pkg::ADDR_FLAGS && i_sw_bit_en == 4'hF
        && !i_irq_entry && no_override |=> o_status_word[7:4] == $past(i_sw_wdata))
        else $error("nibble write to the flag address wrong");
    a_bit_write: assert property (
        i_sw_write && i_sw_addr == status_word_pkg::ADDR_FLAGS && i_sw_bit_en == 4'h2
        && !i_irq_entry && no_override |=> o_status_word[5] == $past(i_sw_wdata[1])
        && o_status_word[7:6] == $past(o_status_word[7:6])
        && o_status_word[4] == $past(o_status_word[4]))
        else $error("single bit write disturbed its neighbours");
    a_write_ignored: assert property (
        i_sw_write && i_sw_addr != status_word_pkg::ADDR_FLAGS
        && !i_irq_entry && no_override |=> $stable(o_status_word[7:4]))
        else $error("write outside the flag address took effect");
    a_entry_level_one: assert property (
        plain_entry && o_nest_level == status_word_pkg::NEST_HIGH_ONLY
        |=> o_nest_level == status_word_pkg::NEST_BLOCK)
        else $error("entry at level one did not reach level two");
    a_push_pulse: assert property (
        !i_irq_entry |=> !o_push_valid && $stable(o_push_word))
        else $error("push strobe or saved word moved without entry");
    a_skip_pulse: assert property (
        !i_carry_test |=> !o_skip_next)
        else $error("skip raised without a carry test");

    c_nested_entry: cover property (plain_entry ##1 plain_entry [*1] ##1 o_nest_level == 2'h2);
    c_return: cover property (plain_entry ##[1:20] i_irq_return);
    c_sw_write: cover property (i_sw_write && i_sw_addr == 12'hFB0);
    c_carry_skip: cover property (i_carry_test && o_carry);
endmodule

// >>> verilog/status_word_pkg.sv
// Constants and types shared by the status word flag logic.
package status_word_pkg;
    localparam int WORD_W = 8;
    localparam int NIB_W = 4;
    localparam int ADDR_W = 12;
    localparam int OFFS_W = 8;
    localparam int SKIP_W = 3;
    localparam int IRQ_N = 6;

    // Status word bit positions.
    localparam int SW_NEST_HI = 7;
    localparam int SW_NEST_LO = 6;
    localparam int SW_EMB = 5;
    localparam int SW_ERB = 4;
    localparam int SW_CARRY = 3;
    localparam int SW_SKIP_LSB = 0;

    // Positions inside the high nibble at the first address.
    localparam int NB_NEST_HI = 3;
    localparam int NB_NEST_LO = 2;
    localparam int NB_EMB = 1;
    localparam int NB_ERB = 0;

    // Vector byte bits that seed the bank enables.
    localparam int VEC_EMB_BIT = 7;
    localparam int VEC_ERB_BIT = 6;

    localparam logic [11:0] ADDR_FLAGS = 12'hFB0;
    localparam logic [11:0] ADDR_CARRY_SKIP = 12'hFB1;

    localparam logic [1:0] NEST_OPEN = 2'h0;
    localparam logic [1:0] NEST_HIGH_ONLY = 2'h1;
    localparam logic [1:0] NEST_BLOCK = 2'h2;
    localparam logic [1:0] NEST_UNDEF = 2'h3;

    localparam logic [3:0] BANK_LOW = 4'h0;
    localparam logic [3:0] BANK_ONE = 4'h1;
    localparam logic [3:0] BANK_IO = 4'hF;
    localparam logic [7:0] WINDOW_SPLIT = 8'h80;
    localparam logic [1:0] REG_BANK_ZERO = 2'h0;

    typedef enum logic [3:0] {
        cop_none,
        cop_arith,
        cop_set,
        cop_clear,
        cop_invert,
        cop_load_bit,
        cop_and_bit,
        cop_or_bit,
        cop_xor_bit
    } carry_op_type;
endpackage

// >>> verilog/irq_nest_gate.sv
// Interrupt acceptance gating by nesting level.
`timescale 1ns/1ps
module irq_nest_gate #(
    parameter int N = status_word_pkg::IRQ_N
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic [1:0] i_nest_level,
    input wire logic [N-1:0] i_pending,
    input wire logic [N-1:0] i_high,
    output logic [N-1:0] o_accept
);
    typedef struct packed {
        logic [N-1:0] accept;
    } gate_state_type;

    gate_state_type st_r;
    gate_state_type st_nxt;

    // Level three is treated like level two, the safe choice for an undefined code.
    always_comb begin
        st_nxt = st_r;
        unique case (i_nest_level)
            status_word_pkg::NEST_OPEN: st_nxt.accept = i_pending;
            status_word_pkg::NEST_HIGH_ONLY: st_nxt.accept = i_pending & i_high;
            status_word_pkg::NEST_BLOCK: st_nxt.accept = '0;
            status_word_pkg::NEST_UNDEF: st_nxt.accept = '0;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_accept = st_r.accept;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    a_block_level: assert property (
        i_nest_level == status_word_pkg::NEST_BLOCK |=> o_accept == '0)
        else $error("request accepted at blocking nesting level");
    a_open_level: assert property (
        i_nest_level == status_word_pkg::NEST_OPEN |=> o_accept == $past(i_pending))
        else $error("open nesting level did not pass pending requests");
    a_high_only: assert property (
        i_nest_level == status_word_pkg::NEST_HIGH_ONLY |=> (o_accept & ~$past(i_high)) == '0)
        else $error("low priority request accepted at level one");
endmodule

// >>> verilog/bank_window.sv
// Data memory bank window and working register bank selection.
`timescale 1ns/1ps
module bank_window (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_emb,
    input wire logic i_erb,
    input wire logic [3:0] i_mem_bank_select,
    input wire logic [1:0] i_reg_bank_select,
    input wire logic [7:0] i_offset,
    output logic [11:0] o_phys_addr,
    output logic o_addr_ok,
    output logic [1:0] o_reg_bank
);
    typedef struct packed {
        logic [11:0] phys;
        logic ok;
        logic [1:0] rbank;
    } win_state_type;

    win_state_type st_r;
    win_state_type st_nxt;

    always_comb begin
        logic low_half;
        low_half = i_offset < status_word_pkg::WINDOW_SPLIT;
        st_nxt = st_r;
        if (!i_emb) begin
            // Bank select is ignored; the offset alone picks bank 0 or bank 15.
            st_nxt.phys = {low_half ? status_word_pkg::BANK_LOW : status_word_pkg::BANK_IO,
                i_offset};
            st_nxt.ok = 1'b1;
        end else begin
            st_nxt.phys = {i_mem_bank_select, i_offset};
            st_nxt.ok = (i_mem_bank_select == status_word_pkg::BANK_LOW)
                || (i_mem_bank_select == status_word_pkg::BANK_ONE)
                || (i_mem_bank_select == status_word_pkg::BANK_IO && !low_half);
        end
        st_nxt.rbank = i_erb ? i_reg_bank_select : status_word_pkg::REG_BANK_ZERO;
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_phys_addr = st_r.phys;
    assign o_addr_ok = st_r.ok;
    assign o_reg_bank = st_r.rbank;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    a_bank_zero: assert property (!i_erb |=> o_reg_bank == 2'h0)
        else $error("register bank not zero with enable clear");
    a_bank_window: assert property (
        !i_emb |=> o_addr_ok && (o_phys_addr[11:8] == 4'h0 || o_phys_addr[11:8] == 4'hF))
        else $error("restricted window reached a bank other than 0 or 15");
endmodule

// >>> tb/status_stack_model.sv
// Sequencer-side model: status word stack and interrupt enable gate.
`timescale 1ns/1ps
module status_stack_model #(
    parameter int IRQ_N = 6,
    parameter int DEPTH = 4
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_push_valid,
    input wire logic [7:0] i_push_word,
    input wire logic i_pop,
    input wire logic i_irq_enable,
    input wire logic [IRQ_N-1:0] i_req,
    output logic [IRQ_N-1:0] o_pending,
    output logic [7:0] o_pop_word
);
    logic [7:0] stack_r [DEPTH];
    logic [7:0] last_r;
    int depth_r;
    // Requests reach the block only while interrupts are enabled, so software
    // can rewrite the nesting flags without an entry racing the write.
    assign o_pending = i_irq_enable ? i_req : '0;
    // An empty stack shows no stale word, only the inverse of the last one popped.
    assign o_pop_word = (depth_r > 0) ? stack_r[depth_r-1] : ~last_r;
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            depth_r <= 0;
            last_r <= 8'h00;
        end else if (i_push_valid && depth_r < DEPTH) begin
            stack_r[depth_r] <= i_push_word;
            depth_r <= depth_r + 1;
        end else if (i_pop && depth_r > 0) begin
            last_r <= stack_r[depth_r-1];
            depth_r <= depth_r - 1;
        end
    end
endmodule

// >>> tb/status_word_flag_logic_tb.sv
// Self-checking bench for the status word flag logic.
`timescale 1ns/1ps
module status_word_flag_logic_tb;
    localparam int N = 6;
    logic i_clock, i_rst_b, i_reset_load, i_irq_entry, i_irq_return, i_sw_write;
    logic i_skip_update, i_arith_carry, i_mem_bit, i_carry_test, irq_en;
    logic [7:0] i_vector_byte, pop_word, i_offset, o_status_word, o_push_word;
    logic [11:0] i_sw_addr, o_phys_addr;
    logic [3:0] i_sw_bit_en, i_sw_wdata, i_mem_bank_select;
    logic [2:0] i_skip_value;
    logic [1:0] i_reg_bank_select, o_nest_level, o_reg_bank;
    logic [N-1:0] req, pending, i_irq_high, o_irq_accept;
    logic o_push_valid, o_carry, o_skip_next, o_addr_ok;
    status_word_pkg::carry_op_type i_carry_op;
    status_word_pkg::carry_op_type op_t [14] = '{status_word_pkg::cop_clear,
        status_word_pkg::cop_set, status_word_pkg::cop_invert, status_word_pkg::cop_invert,
        status_word_pkg::cop_arith, status_word_pkg::cop_arith, status_word_pkg::cop_load_bit,
        status_word_pkg::cop_or_bit, status_word_pkg::cop_and_bit, status_word_pkg::cop_or_bit,
        status_word_pkg::cop_xor_bit, status_word_pkg::cop_and_bit,
        status_word_pkg::cop_xor_bit, status_word_pkg::cop_none};
    logic [13:0] a_v = 14'h2020;
    logic [13:0] m_v = 14'h3C80;
    logic [13:0] c_v = 14'h0CAA;
    logic [5:0] acc_t [4] = '{6'h3F, 6'h05, 6'h00, 6'h00};
    int num_errors = 0;
    int tests_run = 0;

    status_word_flag_logic #(.IRQ_N(N)) i_status_word_flag_logic (
        .i_clock(i_clock), .i_rst_b(i_rst_b), .i_reset_load(i_reset_load),
        .i_irq_entry(i_irq_entry), .i_irq_return(i_irq_return),
        .i_vector_byte(i_vector_byte), .i_pop_word(pop_word), .i_sw_write(i_sw_write),
        .i_sw_addr(i_sw_addr), .i_sw_bit_en(i_sw_bit_en), .i_sw_wdata(i_sw_wdata),
        .i_skip_update(i_skip_update), .i_skip_value(i_skip_value), .i_carry_op(i_carry_op),
        .i_arith_carry(i_arith_carry), .i_mem_bit(i_mem_bit), .i_carry_test(i_carry_test),
        .i_irq_pending(pending), .i_irq_high(i_irq_high),
        .i_mem_bank_select(i_mem_bank_select), .i_reg_bank_select(i_reg_bank_select),
        .i_offset(i_offset), .o_status_word(o_status_word), .o_push_word(o_push_word),
        .o_push_valid(o_push_valid), .o_nest_level(o_nest_level), .o_carry(o_carry),
        .o_skip_next(o_skip_next), .o_irq_accept(o_irq_accept), .o_phys_addr(o_phys_addr),
        .o_addr_ok(o_addr_ok), .o_reg_bank(o_reg_bank));

    status_stack_model #(.IRQ_N(N)) i_status_stack_model (
        .i_clock(i_clock), .i_rst_b(i_rst_b), .i_push_valid(o_push_valid),
        .i_push_word(o_push_word), .i_pop(i_irq_return), .i_irq_enable(irq_en),
        .i_req(req), .o_pending(pending), .o_pop_word(pop_word));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Every pulse is dropped at the edge that samples it, so pulses never overlap.
    task automatic settle();
        @(posedge i_clock);
        i_reset_load <= 1'h0;
        i_irq_entry <= 1'h0;
        i_irq_return <= 1'h0;
        i_sw_write <= 1'h0;
        i_skip_update <= 1'h0;
        i_carry_test <= 1'h0;
        i_carry_op <= status_word_pkg::cop_none;
        #1;
    endtask

    task automatic rload(input logic [7:0] v);
        @(posedge i_clock);
        i_reset_load <= 1'h1;
        i_vector_byte <= v;
        settle();
    endtask

    task automatic entry(input logic [7:0] v);
        @(posedge i_clock);
        i_irq_entry <= 1'h1;
        i_vector_byte <= v;
        settle();
    endtask

    task automatic ret();
        @(posedge i_clock);
        i_irq_return <= 1'h1;
        settle();
    endtask

    task automatic cop(input status_word_pkg::carry_op_type op, input logic a, input logic m);
        @(posedge i_clock);
        i_carry_op <= op;
        i_arith_carry <= a;
        i_mem_bit <= m;
        settle();
    endtask

    task automatic wr(input logic [11:0] addr, input logic [3:0] en, input logic [3:0] d);
        @(posedge i_clock);
        i_sw_write <= 1'h1;
        i_sw_addr <= addr;
        i_sw_bit_en <= en;
        i_sw_wdata <= d;
        settle();
    endtask

    task automatic skip(input logic [2:0] v);
        @(posedge i_clock);
        i_skip_update <= 1'h1;
        i_skip_value <= v;
        settle();
    endtask

    task automatic ctest();
        @(posedge i_clock);
        i_carry_test <= 1'h1;
        settle();
    endtask

    task automatic win(input logic [3:0] sel, input logic [1:0] rsel, input logic [7:0] off);
        @(posedge i_clock);
        i_mem_bank_select <= sel;
        i_reg_bank_select <= rsel;
        i_offset <= off;
        @(posedge i_clock);
        #1;
    endtask

    initial begin
        i_clock = 1'h0;
        forever #12.5 i_clock = ~i_clock;
    end

    initial begin
        #(5000 * 25);
        num_errors++;
        summarize();
    end

    initial begin
        {i_rst_b, i_reset_load, i_irq_entry, i_irq_return, i_sw_write} = '0;
        {i_skip_update, i_arith_carry, i_mem_bit, i_carry_test} = '0;
        {i_vector_byte, i_offset, i_sw_addr, i_sw_bit_en, i_sw_wdata} = '0;
        {i_mem_bank_select, i_skip_value, i_reg_bank_select, req, i_irq_high} = '0;
        i_carry_op = status_word_pkg::cop_none;
        irq_en = 1'h1;
        repeat (20) @(posedge i_clock);
        i_rst_b <= 1'h1;
        settle();
        check(o_status_word, 8'h00);
        rload(8'hC0);
        check(o_status_word, 8'h30);
        cop(status_word_pkg::cop_set, 1'h0, 1'h0);
        skip(3'h7);
        check(o_status_word, 8'h3F);
        rload(8'h40);
        check(o_status_word, 8'h18);
        $display("Test reset loading done");
        for (int i = 0; i < 14; i++) begin
            cop(op_t[i], a_v[i], m_v[i]);
            check(o_carry, c_v[i]);
            check({o_status_word[7:4], o_status_word[2:0]}, 7'h08);
        end
        ctest();
        check(o_skip_next, 1'h0);
        cop(status_word_pkg::cop_set, 1'h0, 1'h0);
        ctest();
        check(o_skip_next, 1'h1);
        settle();
        check(o_skip_next, 1'h0);
        $display("Test carry operations done");
        irq_en <= 1'h0;
        wr(12'hFB1, 4'hF, 4'hF);
        check(o_status_word, 8'h18);
        wr(12'hFB0, 4'h2, 4'hF);
        check(o_status_word, 8'h38);
        wr(12'hFB0, 4'hF, 4'h5);
        check(o_status_word, 8'h58);
        check(o_nest_level, 2'h1);
        @(posedge i_clock);
        req <= 6'h3F;
        i_irq_high <= 6'h05;
        for (int lv = 0; lv < 4; lv++) begin
            irq_en <= 1'h0;
            wr(12'hFB0, 4'hC, {lv[1:0], 2'h0});
            @(posedge i_clock);
            irq_en <= 1'h1;
            @(posedge i_clock);
            #1;
            check(o_irq_accept, acc_t[lv]);
        end
        irq_en <= 1'h0;
        wr(12'hFB0, 4'hF, 4'h1);
        irq_en <= 1'h1;
        check(o_status_word, 8'h18);
        $display("Test nesting gate done");
        skip(3'h5);
        entry(8'h80);
        check(o_push_valid, 1'h1);
        check(o_push_word, 8'h1D);
        check(o_status_word, 8'h6D);
        settle();
        check(o_push_valid, 1'h0);
        check(o_irq_accept, 6'h05);
        cop(status_word_pkg::cop_clear, 1'h0, 1'h0);
        entry(8'h40);
        check(o_push_word, 8'h65);
        check(o_status_word, 8'h95);
        settle();
        check(o_irq_accept, 6'h00);
        ret();
        check(o_status_word, 8'h65);
        ret();
        check(o_status_word, 8'h1D);
        $display("Test entry and return done");
        win(4'h1, 2'h3, 8'h34);
        check({o_addr_ok, o_phys_addr}, 13'h1034);
        check(o_reg_bank, 2'h3);
        win(4'h0, 2'h3, 8'h90);
        check({o_addr_ok, o_phys_addr}, 13'h1F90);
        wr(12'hFB0, 4'h3, 4'h2);
        win(4'h1, 2'h3, 8'h34);
        check({o_addr_ok, o_phys_addr}, 13'h1134);
        check(o_reg_bank, 2'h0);
        win(4'h0, 2'h2, 8'h90);
        check({o_addr_ok, o_phys_addr}, 13'h1090);
        win(4'hF, 2'h2, 8'h90);
        check({o_addr_ok, o_phys_addr}, 13'h1F90);
        win(4'hF, 2'h2, 8'h20);
        check(o_addr_ok, 1'h0);
        win(4'h2, 2'h2, 8'h10);
        check(o_addr_ok, 1'h0);
        $display("Test bank window done");
        summarize();
    end
endmodule
